// file: logic/prot_pkg.sv
// constants for the cell protection state machine
package prot_pkg;
    // delay oscillator and delay figures
    localparam int OSC_HZ = 3500;
    localparam int CLK_HZ = 40000000;
    localparam int OVERCHARGE_DELAY_MS = 100;
    localparam int OVERDISCHARGE_DELAY_MS = 25;
    localparam int OVERCURRENT_DELAY_MS = 10;
    localparam int SHORT_DELAY_US = 500;
    // oscillator divider in clk cycles, rounded down
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    // delays in oscillator ticks, rounded down to stay inside the typical figure
    localparam int OVERCHARGE_TICKS = OVERCHARGE_DELAY_MS * OSC_HZ / 1000;
    localparam int OVERDISCHARGE_TICKS = OVERDISCHARGE_DELAY_MS * OSC_HZ / 1000;
    localparam int OVERCURRENT_TICKS = OVERCURRENT_DELAY_MS * OSC_HZ / 1000;
    localparam int SHORT_TICKS = SHORT_DELAY_US * OSC_HZ / 1000000;
    localparam int TICK_W = 16;

    typedef enum logic [2:0] {
        ST_START = 3'b000,
        ST_NORMAL = 3'b001,
        ST_OVERCURRENT = 3'b010,
        ST_OVERCHARGE = 3'b011,
        ST_OVERDISCHARGE = 3'b100
    } prot_state_type;
endpackage

// file: logic/battery_protection_fsm.sv
// protection state machine driving charge and discharge gates
// What this block does
// - normal keeps both gates on, charge gate only with no abnormal charge and no zero volt cell
// - sustained overcurrent turns discharge gate off
// - pulldown on sense pin during overcurrent
// - overcurrent ends when sense falls back
// - sustained overcharge turns charge gate off
// - no charger: release below release threshold
// - load plus below overcharge releases overcharge
// - overcurrent detection off above overcharge threshold
// - charger keeps overcharge until charger removed
// - overdischarge qualified for its delay
// - short qualified for short delay
// - start state exits on grounded sense or charger
// - delays count a slow internal oscillator
// - sustained undervoltage turns discharge gate off
// - sustained charger current turns charge gate off
// - zero volt cell forces charge gate off
module battery_protection_fsm
    import prot_pkg::*;
#(
    parameter int OSC_DIVIDE = OSC_DIV,
    parameter int OVERCHARGE_LEN = OVERCHARGE_TICKS,
    parameter int OVERDISCHARGE_LEN = OVERDISCHARGE_TICKS,
    parameter int OVERCURRENT_LEN = OVERCURRENT_TICKS,
    parameter int SHORT_LEN = SHORT_TICKS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cell_above_overcharge,
    input wire logic cell_below_release,
    input wire logic cell_below_overdischarge,
    input wire logic cell_below_zero_volt,
    input wire logic sense_above_overcurrent,
    input wire logic sense_above_short,
    input wire logic sense_below_charger,
    input wire logic sense_near_ground,
    output logic charge_gate,
    output logic discharge_gate,
    output logic sense_pulldown
);

////////////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers; stage one is read only by stage two
    logic [7:0] sync1;
    logic [7:0] sync2;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else begin
            sync1 <= {cell_above_overcharge, cell_below_release, cell_below_overdischarge,
                      cell_below_zero_volt, sense_above_overcurrent, sense_above_short,
                      sense_below_charger, sense_near_ground};
            sync2 <= sync1;
        end
    end
    wire over_chg = sync2[7];
    wire below_rel = sync2[6];
    wire below_od = sync2[5];
    wire zero_volt = sync2[4];
    wire over_cur = sync2[3];
    wire short_cur = sync2[2];
    wire charger = sync2[1];
    wire sense_gnd = sync2[0];

////////////////////////////////////////////////////////////////////////////////
    // oscillator tick every OSC_DIVIDE clk cycles, so delays scale with the clk period
    logic [TICK_W-1:0] osc_cnt;
    wire tick = (osc_cnt == TICK_W'(OSC_DIVIDE - 1));
    always_ff @(posedge clk) begin
        if (!rstn || tick) osc_cnt <= '0;
        else osc_cnt <= osc_cnt + 1'b1;
    end

    // one qualifying counter per detection; 'done' once held for len ticks
    function automatic logic [TICK_W-1:0] step(input logic cond, input logic [TICK_W-1:0] cnt,
                                               input logic tk, input logic [TICK_W-1:0] len);
        if (!cond) step = '0;
        else if (tk && cnt < len) step = cnt + 1'b1;
        else step = cnt;
    endfunction

    prot_state_type state, next_state;
    logic [TICK_W-1:0] oc_cnt, od_cnt, cur_cnt, sh_cnt, ab_cnt;
    wire cur_enable = !over_chg;
    wire oc_cond = (state == ST_NORMAL) && over_chg;
    wire od_cond = (state == ST_NORMAL) && below_od;
    wire cur_cond = (state == ST_NORMAL) && cur_enable && over_cur;
    wire sh_cond = (state == ST_NORMAL) && cur_enable && short_cur;
    wire ab_cond = (state == ST_NORMAL) && charger && discharge_gate;
    wire oc_done = (oc_cnt == TICK_W'(OVERCHARGE_LEN));
    wire od_done = (od_cnt == TICK_W'(OVERDISCHARGE_LEN));
    wire cur_done = (cur_cnt == TICK_W'(OVERCURRENT_LEN));
    wire sh_done = (sh_cnt == TICK_W'(SHORT_LEN));
    wire ab_done = (ab_cnt == TICK_W'(OVERCHARGE_LEN));
    always_ff @(posedge clk) begin
        if (!rstn) begin
            oc_cnt <= '0;
            od_cnt <= '0;
            cur_cnt <= '0;
            sh_cnt <= '0;
            ab_cnt <= '0;
        end else begin
            oc_cnt <= step(oc_cond, oc_cnt, tick, TICK_W'(OVERCHARGE_LEN));
            od_cnt <= step(od_cond, od_cnt, tick, TICK_W'(OVERDISCHARGE_LEN));
            cur_cnt <= step(cur_cond, cur_cnt, tick, TICK_W'(OVERCURRENT_LEN));
            sh_cnt <= step(sh_cond, sh_cnt, tick, TICK_W'(SHORT_LEN));
            ab_cnt <= step(ab_cond, ab_cnt, tick, TICK_W'(OVERCHARGE_LEN));
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // charger seen while in overcharge; cleared only on leaving overcharge
    logic chg_latched;
    always_ff @(posedge clk) begin
        if (!rstn || state != ST_OVERCHARGE) chg_latched <= 1'b0;
        else if (charger) chg_latched <= 1'b1;
    end
    // abnormal charge latch; released once sense leaves charger range
    logic abnormal;
    always_ff @(posedge clk) begin
        if (!rstn) abnormal <= 1'b0;
        else if (ab_done) abnormal <= 1'b1;
        else if (!charger) abnormal <= 1'b0;
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_START: if (sense_gnd || charger) next_state = ST_NORMAL;
            ST_NORMAL: begin
                if (cur_done || sh_done) next_state = ST_OVERCURRENT;
                else if (od_done) next_state = ST_OVERDISCHARGE;
                else if (oc_done) next_state = ST_OVERCHARGE;
            end
            ST_OVERCURRENT: if (!over_cur) next_state = ST_NORMAL;
            ST_OVERCHARGE: begin
                if (chg_latched || charger) begin
                    if (!charger && chg_latched) next_state = ST_NORMAL;
                end else if (below_rel) next_state = ST_NORMAL;
                else if (!over_chg && over_cur) next_state = ST_NORMAL;
            end
            ST_OVERDISCHARGE: if (!below_od) next_state = ST_NORMAL;
            default: next_state = ST_START;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rstn) state <= ST_START;
        else state <= next_state;
    end

////////////////////////////////////////////////////////////////////////////////
    wire dis_on = (state == ST_NORMAL) || (state == ST_OVERCHARGE);
    wire chg_on = (state != ST_OVERCHARGE) && !abnormal && !zero_volt;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            charge_gate <= 1'b0;
            discharge_gate <= 1'b0;
            sense_pulldown <= 1'b0;
        end else begin
            charge_gate <= chg_on;
            discharge_gate <= dis_on;
            sense_pulldown <= (next_state == ST_OVERCURRENT);
        end
    end

////////////////////////////////////////////////////////////////////////////////
    sequence cur_held_s;
        cur_done && state == ST_NORMAL;
    endsequence
    // gates follow the state one edge later, so each trip takes two steps
    sequence to_overcurrent_s;
        state == ST_OVERCURRENT ##1 !discharge_gate;
    endsequence
    sequence to_overdischarge_s;
        state == ST_OVERDISCHARGE ##1 !discharge_gate;
    endsequence
    normal_gates_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_NORMAL && $past(state) == ST_NORMAL && !$past(abnormal) && !$past(zero_volt)
        |-> charge_gate && discharge_gate) else $error("normal gates not on");
    overcur_off_a: assert property (@(posedge clk) disable iff (!rstn)
        cur_held_s |=> to_overcurrent_s)
        else $error("overcurrent did not cut discharge");
    pulldown_on_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_OVERCURRENT |-> sense_pulldown) else $error("pulldown missing");
    overcur_rel_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_OVERCURRENT && !over_cur |=> state == ST_NORMAL ##1 discharge_gate)
        else $error("overcurrent not released");
    overchg_off_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_NORMAL && oc_done && !cur_done && !sh_done && !od_done
        |=> state == ST_OVERCHARGE ##1 !charge_gate) else $error("overcharge not cut");
    overchg_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_OVERCHARGE && charger |=> state == ST_OVERCHARGE)
        else $error("overcharge left with charger");
    cur_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        over_chg |=> cur_cnt == '0 && sh_cnt == '0) else $error("overcurrent armed");
    zero_volt_a: assert property (@(posedge clk) disable iff (!rstn)
        zero_volt |=> !charge_gate) else $error("zero volt cell charging");
    restart_a: assert property (@(posedge clk) disable iff (!rstn)
        !od_cond |=> od_cnt == '0) else $error("counter kept count");
    start_exit_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_START && sense_gnd |=> state == ST_NORMAL) else $error("start stuck");
    start_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_START && $past(state) == ST_START |-> !discharge_gate)
        else $error("discharge on before start exit");
    short_cut_a: assert property (@(posedge clk) disable iff (!rstn)
        sh_done && state == ST_NORMAL |=> to_overcurrent_s)
        else $error("short did not cut discharge");
    undervolt_cut_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_NORMAL && od_done && !cur_done && !sh_done |=> to_overdischarge_s)
        else $error("undervoltage did not cut discharge");
    overchg_rel_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_OVERCHARGE && !chg_latched && !charger && below_rel
        |=> state == ST_NORMAL) else $error("overcharge not released");
    load_rel_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_OVERCHARGE && !chg_latched && !charger && !over_chg && over_cur
        |=> state == ST_NORMAL) else $error("load did not release overcharge");
    charger_rel_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_OVERCHARGE && chg_latched && !charger
        |=> state == ST_NORMAL) else $error("charger removal not seen");
    abnormal_cut_a: assert property (@(posedge clk) disable iff (!rstn)
        ab_done |=> abnormal ##1 !charge_gate) else $error("abnormal charge not cut");
endmodule // battery_protection_fsm

// file: dv/pack_model.sv
// behavioural battery pack, fets, charger and load around the gates
module pack_model (
    input wire logic charge_gate,
    input wire logic discharge_gate,
    input wire logic sense_pulldown,
    input wire logic [2:0] cell_level,
    input wire logic [1:0] load,
    input wire logic charger,
    input wire logic sense_short,
    output logic cell_above_overcharge,
    output logic cell_below_release,
    output logic cell_below_overdischarge,
    output logic cell_below_zero_volt,
    output logic sense_above_overcurrent,
    output logic sense_above_short,
    output logic sense_below_charger,
    output logic sense_near_ground
);
    timeunit 1ns;
    timeprecision 1ps;
    // cell levels: 0 dead, 1 under, 2 low, 3 high, 4 overcharged
    assign cell_above_overcharge = cell_level == 3'h4;
    assign cell_below_release = cell_level <= 3'h2;
    assign cell_below_overdischarge = cell_level <= 3'h1;
    assign cell_below_zero_volt = cell_level == 3'h0;
    ////////////////////////////////////////////////////////////////////
    // no fet path and no pulldown: sense floats up to the cell
    // pack terminals shorted by hand pull sense to ground as well
    wire logic floating = !discharge_gate && !sense_pulldown && !charger && !sense_short;
    assign sense_above_overcurrent = load != 2'h0 || floating;
    assign sense_above_short = load == 2'h2 || (load != 2'h0 && !discharge_gate);
    assign sense_below_charger = charger && load == 2'h0;
    assign sense_near_ground = sense_short || (load == 2'h0 && !charger && !floating);
endmodule // pack_model

// file: dv/battery_protection_fsm_test.sv
// self-checking bench for the cell protection state machine
module battery_protection_fsm_test;
    timeunit 1ns;
    timeprecision 1ps;
    // short counts keep the run brief
    localparam int DIV = 2;
    localparam int OCH = 6;
    localparam int ODS = 5;
    localparam int OCU = 8;
    localparam int SHT = 2;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] cell_level = 3'h3;
    logic [1:0] load = 2'h0;
    logic charger = 1'b0;
    logic sense_short = 1'b0;
    logic charge_gate, discharge_gate, sense_pulldown, cell_above_overcharge;
    logic cell_below_release, cell_below_overdischarge, cell_below_zero_volt;
    logic sense_above_overcurrent, sense_above_short, sense_below_charger, sense_near_ground;
    int num_errors = 0;
    int checks = 0;
    always #12.5 clk = ~clk;
    battery_protection_fsm #(.OSC_DIVIDE(DIV), .OVERCHARGE_LEN(OCH),
        .OVERDISCHARGE_LEN(ODS), .OVERCURRENT_LEN(OCU), .SHORT_LEN(SHT)) i_dut (
        .clk, .rstn, .cell_above_overcharge, .cell_below_release, .cell_below_overdischarge,
        .cell_below_zero_volt, .sense_above_overcurrent, .sense_above_short,
        .sense_below_charger, .sense_near_ground, .charge_gate, .discharge_gate,
        .sense_pulldown);
    pack_model i_pack (.charge_gate, .discharge_gate, .sense_pulldown, .cell_level,
        .load, .charger, .sense_short, .cell_above_overcharge, .cell_below_release,
        .cell_below_overdischarge, .cell_below_zero_volt, .sense_above_overcurrent,
        .sense_above_short, .sense_below_charger, .sense_near_ground);
    ////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic drive(input logic [2:0] c, input logic [1:0] l, input logic ch);
        @(posedge clk);
        cell_level <= c;
        load <= l;
        charger <= ch;
    endtask
    // full qualification plus synchroniser, tick phase and gate edge
    function automatic int qual(input int len);
        return (len + 2) * DIV + 6;
    endfunction
    function automatic logic [2:0] nrm();
        return 3'h2 + 3'($urandom_range(1));
    endfunction
    task automatic check(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        step(3000);
        num_errors++;
        summarize();
    end
    initial begin
        int g;
        void'($urandom(32'h32fe));
        step(16);
        check("discharge_gate in reset", 1'b0, discharge_gate);
        @(posedge clk) rstn <= 1'b1;
        step(6);
        check("discharge_gate start", 1'b0, discharge_gate);
        @(posedge clk) sense_short <= 1'b1;
        step(6);
        @(posedge clk) sense_short <= 1'b0;
        step(8);
        check("both gates", 1'b1, charge_gate & discharge_gate);
        for (int i = 0; i < 2; i++) begin
            g = $urandom_range(1, OCU - 3) * DIV;
            drive(nrm(), 2'h1, 1'b0);
            step(g);
            drive(nrm(), 2'h0, 1'b0);
            step(6);
        end
        check("discharge_gate glitch", 1'b1, discharge_gate);
        drive(nrm(), 2'h1, 1'b0);
        step(qual(OCU));
        check("discharge_gate overcurrent", 1'b0, discharge_gate);
        check("sense_pulldown", 1'b1, sense_pulldown);
        drive(nrm(), 2'h0, 1'b0);
        step(8);
        check("discharge_gate back", 1'b1, discharge_gate);
        drive(nrm(), 2'h2, 1'b0);
        step(qual(SHT));
        check("discharge_gate short", 1'b0, discharge_gate);
        drive(3'h4, 2'h0, 1'b0);
        step(qual(OCH));
        check("charge_gate overcharge", 1'b0, charge_gate);
        drive(3'h2, 2'h0, 1'b0);
        step(6);
        check("charge_gate release", 1'b1, charge_gate);
        drive(3'h4, 2'h0, 1'b0);
        step(qual(OCH));
        drive(3'h2, 2'h0, 1'b1);
        step(qual(OCH));
        check("charge_gate charger on", 1'b0, charge_gate);
        drive(3'h2, 2'h0, 1'b0);
        step(6);
        check("charge_gate charger off", 1'b1, charge_gate);
        // short load while overcharged: a live short counter would trip first
        drive(3'h4, 2'h2, 1'b0);
        step(qual(OCH));
        check("discharge_gate overcharged", 1'b1, discharge_gate);
        check("charge_gate overcharged", 1'b0, charge_gate);
        drive(3'h3, 2'h1, 1'b0);
        step(8);
        check("charge_gate load release", 1'b1, charge_gate);
        drive(3'h3, 2'h0, 1'b0);
        step(8);
        drive(3'h1, 2'h0, 1'b0);
        step(ODS * DIV - 2);
        check("discharge_gate early", 1'b1, discharge_gate);
        step(qual(ODS));
        check("discharge_gate undervoltage", 1'b0, discharge_gate);
        drive(nrm(), 2'h0, 1'b0);
        step(8);
        drive(3'h3, 2'h0, 1'b1);
        step(qual(OCH));
        check("charge_gate abnormal", 1'b0, charge_gate);
        drive(3'h3, 2'h0, 1'b0);
        step(6);
        check("charge_gate abnormal clear", 1'b1, charge_gate);
        drive(3'h0, 2'h0, 1'b0);
        step(6);
        check("charge_gate dead cell", 1'b0, charge_gate);
        summarize();
    end
endmodule // battery_protection_fsm_test
